// *** inc/arc_pkg.sv ***
package arc_pkg;
	// Chip operating modes, one-hot
	typedef enum logic [5:0] {
		ARC_MODE_INIT = 6'h01,
		ARC_MODE_NORMAL = 6'h02,
		ARC_MODE_STOP = 6'h04,
		ARC_MODE_SLEEP = 6'h08,
		ARC_MODE_RESTART = 6'h10,
		ARC_MODE_FAILSAFE = 6'h20
	} arc_mode_t;

	// Configuration lock state, one-hot
	typedef enum logic [2:0] {
		ARC_CFG_NONE = 3'h1,
		ARC_CFG_ALONE = 3'h2,
		ARC_CFG_SHARE = 3'h4
	} arc_cfg_t;

	// Host control bits as written over SPI
	typedef struct packed {
		logic aux_reg_on;
		logic aux_load_share_sel;
		logic aux_voltage_select;
		logic aux_uv_stay_off;
		logic aux_share_stop_keep;
	} arc_ctrl_t;

	// Status word reported in the second supply status register
	typedef struct packed {
		logic aux_overcurrent_flag;
		logic aux_undervoltage_flag;
		logic aux_enabled;
		logic aux_share_cfg;
		logic aux_alone_cfg;
	} arc_status_t;

	localparam logic ARC_RST_BIT = 1'h0;
	localparam logic ARC_LEVEL_3V3 = 1'h0;
	localparam logic ARC_LEVEL_1V8 = 1'h1;
	localparam int ARC_UV_FILTER_NS = 1000;
	localparam int ARC_CLK_PERIOD_NS = 10;
	localparam int ARC_UV_FILTER_CYC = (ARC_UV_FILTER_NS + ARC_CLK_PERIOD_NS - 1) / ARC_CLK_PERIOD_NS;
endpackage

// *** hdl/arc_cfg_lock.sv ***
`timescale 1ns/1ns
module arc_cfg_lock
	import arc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic por_in,
	input wire logic wr_strobe_in,
	input wire logic mode_normal_in,
	input wire arc_ctrl_t wr_ctrl_in,
	output arc_cfg_t cfg_out,
	output logic spi_fail_out
);
	arc_cfg_t next_cfg;
	logic next_spi_fail;
	wire logic pick_alone = wr_strobe_in && mode_normal_in && wr_ctrl_in.aux_reg_on
		&& !wr_ctrl_in.aux_load_share_sel;
	wire logic pick_share = wr_strobe_in && wr_ctrl_in.aux_load_share_sel;
	// A change attempt is any write with aux_reg_on set or aux_load_share_sel clear once sharing is locked
	wire logic share_change = wr_strobe_in && (cfg_out == ARC_CFG_SHARE)
		&& (wr_ctrl_in.aux_reg_on || !wr_ctrl_in.aux_load_share_sel);

	// Latch only out of the unconfigured state; soft reset does not reach here
	always_comb begin
		next_cfg = cfg_out;
		next_spi_fail = share_change;
		unique case (cfg_out)
			ARC_CFG_NONE: begin
				if (pick_share) begin
					next_cfg = ARC_CFG_SHARE;
				end else if (pick_alone) begin
					next_cfg = ARC_CFG_ALONE;
				end
			end
			ARC_CFG_ALONE: next_cfg = ARC_CFG_ALONE;
			ARC_CFG_SHARE: next_cfg = ARC_CFG_SHARE;
			default: next_cfg = ARC_CFG_NONE;
		endcase
	end

	// Power-on reset only: configuration survives soft reset
	always_ff @(posedge sys_clk_in) begin
		if (por_in) begin
			cfg_out <= ARC_CFG_NONE;
			spi_fail_out <= ARC_RST_BIT;
		end else begin
			cfg_out <= next_cfg;
			spi_fail_out <= next_spi_fail;
		end
	end
endmodule

// *** hdl/arc_uv_filter.sv ***
`timescale 1ns/1ns
module arc_uv_filter
	import arc_pkg::*;
#(
	parameter int FILTER_CYC = ARC_UV_FILTER_CYC
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic raw_uv_in,
	output logic uv_out
);
	localparam int CW = $clog2(FILTER_CYC + 1);
	localparam logic [CW-1:0] CNT_TOP = CW'(FILTER_CYC);
	logic [CW-1:0] cnt;

	// Elaboration guard: a zero window leaves the counter nothing to count
	if (FILTER_CYC < 1) begin
		$error("FILTER_CYC must be at least 1");
	end

	// Level must persist the whole window before uv_out follows; rejects glitches
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cnt <= '0;
			uv_out <= ARC_RST_BIT;
		end else if (raw_uv_in == uv_out) begin
			cnt <= '0;
		end else if (cnt == CNT_TOP - CW'(1)) begin
			cnt <= '0;
			uv_out <= raw_uv_in;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end
endmodule

// *** hdl/arc_aux_reg_ctrl.sv ***
`timescale 1ns/1ns
module arc_aux_reg_ctrl
	import arc_pkg::*;
#(
	parameter int UV_FILTER_CYC = ARC_UV_FILTER_CYC
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic por_in,
	input wire arc_mode_t mode_in,
	input wire logic ctrl_wr_in,
	input wire arc_ctrl_t ctrl_in,
	input wire logic main_level_1v8_in,
	input wire logic main_enabled_in,
	input wire logic supply_uv_in,
	input wire logic shunt_limit_in,
	input wire logic oc_clear_in,
	output logic aux_enable_out,
	output logic aux_level_1v8_out,
	output logic aux_high_power_out,
	output logic aux_low_power_allow_out,
	output logic aux_current_limit_out,
	output logic spi_fail_out,
	output arc_status_t status_out,
	output arc_cfg_t cfg_out
);
	arc_cfg_t cfg;
	logic lock_fail;
	logic uv_filt;
	logic uv_seen;
	arc_ctrl_t ctrl;
	logic next_enable;

	// Elaboration guard: the debounce needs at least one cycle of window
	if (UV_FILTER_CYC < 1) begin
		$error("UV_FILTER_CYC must be at least 1");
	end

	arc_cfg_lock u_lock (
		.sys_clk_in(sys_clk_in),
		.por_in(por_in),
		.wr_strobe_in(ctrl_wr_in),
		.mode_normal_in(mode_in == ARC_MODE_NORMAL),
		.wr_ctrl_in(ctrl_in),
		.cfg_out(cfg),
		.spi_fail_out(lock_fail)
	);

	// Supply undervoltage debounce
	arc_uv_filter #(
		.FILTER_CYC(UV_FILTER_CYC)
	) u_uv (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.raw_uv_in(supply_uv_in),
		.uv_out(uv_filt)
	);

	// Configuration and mode decodes
	wire logic is_alone = (cfg == ARC_CFG_ALONE);
	wire logic is_share = (cfg == ARC_CFG_SHARE);
	wire logic in_normal = (mode_in == ARC_MODE_NORMAL);
	wire logic in_stop = (mode_in == ARC_MODE_STOP);

	wire logic on_req = is_alone ? ctrl.aux_reg_on : (is_share && ctrl.aux_load_share_sel);

	wire logic uv_block = uv_filt || (uv_seen && ctrl.aux_uv_stay_off);

	always_comb begin
		next_enable = 1'b0;
		unique case (mode_in)
			ARC_MODE_INIT: next_enable = 1'b0;
			ARC_MODE_NORMAL: next_enable = on_req;
			ARC_MODE_STOP: next_enable = is_alone ? ctrl.aux_reg_on
				: (is_share && ctrl.aux_load_share_sel && ctrl.aux_share_stop_keep);
			ARC_MODE_SLEEP: next_enable = is_alone && ctrl.aux_reg_on;
			ARC_MODE_RESTART: next_enable = is_alone ? ctrl.aux_reg_on : (is_share && main_enabled_in);
			ARC_MODE_FAILSAFE: next_enable = 1'b0;
			default: next_enable = 1'b0;
		endcase
	end

	wire logic next_level = is_share ? main_level_1v8_in
		: (ctrl.aux_voltage_select ? ARC_LEVEL_1V8 : ARC_LEVEL_3V3);

	wire logic oc_event = is_alone && aux_enable_out && shunt_limit_in;

	// Control bits are written in Normal only, so Stop/Sleep hold fixed settings
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ctrl <= '0;
		end else if (ctrl_wr_in && in_normal) begin
			ctrl <= ctrl_in;
		end
	end

	// Sticky undervoltage memory; cleared once the filtered undervoltage is gone and stay-off is low
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			uv_seen <= ARC_RST_BIT;
		end else if (uv_filt) begin
			uv_seen <= 1'b1;
		end else if (!ctrl.aux_uv_stay_off) begin
			uv_seen <= 1'b0;
		end
	end

	// Regulator drive outputs
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			aux_enable_out <= ARC_RST_BIT;
			aux_level_1v8_out <= ARC_LEVEL_3V3;
			aux_high_power_out <= ARC_RST_BIT;
			aux_low_power_allow_out <= ARC_RST_BIT;
			aux_current_limit_out <= ARC_RST_BIT;
		end else begin
			aux_enable_out <= next_enable && !uv_block;
			aux_level_1v8_out <= next_level;
			aux_high_power_out <= next_enable && !uv_block && (in_normal || !in_stop);
			aux_low_power_allow_out <= next_enable && !uv_block && in_stop;
			aux_current_limit_out <= oc_event;
		end
	end

	// status word, sticky flag: set wins over clear
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			status_out <= '0;
		end else begin
			status_out.aux_overcurrent_flag <= oc_event || (status_out.aux_overcurrent_flag && !oc_clear_in);
			status_out.aux_undervoltage_flag <= is_alone && uv_filt;
			status_out.aux_enabled <= next_enable && !uv_block;
			status_out.aux_share_cfg <= is_share;
			status_out.aux_alone_cfg <= is_alone;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (por_in) begin
			spi_fail_out <= ARC_RST_BIT;
			cfg_out <= ARC_CFG_NONE;
		end else begin
			spi_fail_out <= lock_fail;
			cfg_out <= cfg;
		end
	end
endmodule

// *** verification/arc_aux_reg_ctrl_monitor.sv ***
`timescale 1ns/1ns
module arc_aux_reg_ctrl_monitor
	import arc_pkg::*;
#(
	parameter int UV_FILTER_CYC = ARC_UV_FILTER_CYC
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic por_in,
	input wire arc_mode_t mode_in,
	input wire logic ctrl_wr_in,
	input wire arc_ctrl_t ctrl_in,
	input wire logic main_level_1v8_in,
	input wire logic supply_uv_in,
	input wire logic shunt_limit_in,
	input wire logic aux_enable_out,
	input wire logic aux_level_1v8_out,
	input wire logic spi_fail_out,
	input wire arc_status_t status_out,
	input wire arc_cfg_t cfg_out
);
	int uv_run;
	// Run length of undervoltage; the filter is a parameter, so a count beats a repetition
	always_ff @(posedge sys_clk_in) begin
		uv_run <= (supply_uv_in && !sys_rst_in) ? uv_run + 1 : 0;
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in || por_in);
	// First write with no lock pending, even from a write two cycles back
	sequence s_fresh;
		ctrl_wr_in && cfg_out == ARC_CFG_NONE && !$past(ctrl_wr_in) && !$past(ctrl_wr_in, 2);
	endsequence
	share_lock_a: assert property (s_fresh ##0 ctrl_in.aux_load_share_sel |-> ##2 cfg_out == ARC_CFG_SHARE)
		else $error("share lock missed");
	alone_lock_a: assert property (s_fresh ##0 (ctrl_in.aux_reg_on && !ctrl_in.aux_load_share_sel && mode_in == ARC_MODE_NORMAL) |-> ##2 cfg_out == ARC_CFG_ALONE)
		else $error("standalone lock missed");
	cfg_keep_a: assert property (@(posedge sys_clk_in) disable iff (por_in) cfg_out != ARC_CFG_NONE |=> $stable(cfg_out))
		else $error("locked config changed");
	share_fail_a: assert property (ctrl_wr_in && cfg_out == ARC_CFG_SHARE && ctrl_in.aux_reg_on |-> ##2 spi_fail_out)
		else $error("rejected write not flagged");
	off_modes_a: assert property ((mode_in == ARC_MODE_INIT || mode_in == ARC_MODE_FAILSAFE)[*3] |-> !aux_enable_out)
		else $error("regulator on in off mode");
	share_follow_a: assert property ((cfg_out == ARC_CFG_SHARE && $stable(main_level_1v8_in))[*3] |-> aux_level_1v8_out == main_level_1v8_in)
		else $error("sharing level not following main");
	uv_off_a: assert property (uv_run > UV_FILTER_CYC + 2 |-> !aux_enable_out)
		else $error("regulator on in undervoltage");
	oc_set_a: assert property (cfg_out == ARC_CFG_ALONE && aux_enable_out && shunt_limit_in |=> status_out.aux_overcurrent_flag)
		else $error("overcurrent flag missed");
endmodule
bind arc_aux_reg_ctrl arc_aux_reg_ctrl_monitor #(.UV_FILTER_CYC(UV_FILTER_CYC)) mon (.*);

// *** verification/arc_host_model.sv ***
`timescale 1ns/1ns
module arc_host_model
	import arc_pkg::*;
(
	input wire logic sys_clk_in,
	output logic ctrl_wr_out,
	output arc_ctrl_t ctrl_out
);
	initial begin
		ctrl_wr_out = 1'h0;
		ctrl_out = 5'h00;
	end
	task automatic send(input arc_ctrl_t val);
		@(negedge sys_clk_in);
		ctrl_wr_out = 1'h1;
		ctrl_out = val;
		@(negedge sys_clk_in);
		ctrl_wr_out = 1'h0;
		// Released data is inverted so a stale value never looks valid
		ctrl_out = ~val;
	endtask
endmodule

// *** verification/aux_regulator_config_control_tb_top.sv ***
`timescale 1ns/1ns
module aux_regulator_config_control_tb_top;
	import arc_pkg::*;
	logic sys_clk_in;
	logic rst, por, m_lvl, m_en, uv, sh, clr;
	arc_mode_t mode;
	logic wr, en, lvl, hp, lp, lim, fail;
	arc_ctrl_t ctrl;
	arc_status_t st;
	arc_cfg_t cfg;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;
	arc_host_model host (.sys_clk_in(sys_clk_in), .ctrl_wr_out(wr), .ctrl_out(ctrl));
	arc_aux_reg_ctrl #(.UV_FILTER_CYC(2)) dut (.sys_clk_in(sys_clk_in), .sys_rst_in(rst), .por_in(por),
		.mode_in(mode), .ctrl_wr_in(wr), .ctrl_in(ctrl), .main_level_1v8_in(m_lvl), .main_enabled_in(m_en),
		.supply_uv_in(uv), .shunt_limit_in(sh), .oc_clear_in(clr), .aux_enable_out(en), .aux_level_1v8_out(lvl),
		.aux_high_power_out(hp), .aux_low_power_allow_out(lp), .aux_current_limit_out(lim),
		.spi_fail_out(fail), .status_out(st), .cfg_out(cfg));
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	task automatic chk(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Sharing: voltage select ignored, refused change, mode table, soft reset
	task automatic t_share();
		arc_mode_t md[5] = '{ARC_MODE_STOP, ARC_MODE_SLEEP, ARC_MODE_RESTART, ARC_MODE_INIT, ARC_MODE_FAILSAFE};
		logic ex[5] = '{1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
		host.send(5'h0C);
		cyc(2);
		chk(cfg === ARC_CFG_SHARE, 1'h1);
		chk(lvl, 1'h0);
		m_lvl = 1'h1;
		host.send(5'h10);
		// The failure flag is a one-cycle pulse, so look while it stands
		cyc(1);
		chk(fail, 1'h1);
		cyc(1);
		chk(cfg === ARC_CFG_SHARE, 1'h1);
		chk(lvl, 1'h1);
		chk(st.aux_share_cfg & ~st.aux_alone_cfg, 1'h1);
		host.send(5'h08);
		cyc(2);
		chk(en, 1'h1);
		for (int i = 0; i < 5; i++) begin
			mode = md[i];
			cyc(3);
			chk(en, ex[i]);
		end
		// Restart sharing must track the main regulator both ways
		mode = ARC_MODE_RESTART;
		m_en = 1'h0;
		cyc(3);
		chk(en, 1'h0);
		m_en = 1'h1;
		cyc(3);
		chk(en, 1'h1);
		mode = ARC_MODE_NORMAL;
		host.send(5'h09);
		mode = ARC_MODE_STOP;
		cyc(3);
		chk(en, 1'h1);
		chk(lp & ~hp, 1'h1);
		chk(st.aux_enabled, 1'h1);
		rst = 1'h1;
		cyc(2);
		rst = 1'h0;
		cyc(1);
		chk(cfg === ARC_CFG_SHARE, 1'h1);
	endtask
	// Standalone: level select, ignored share write, undervoltage, overcurrent
	task automatic t_alone();
		por = 1'h1;
		mode = ARC_MODE_NORMAL;
		m_lvl = 1'h0;
		cyc(2);
		chk(cfg === ARC_CFG_NONE, 1'h1);
		por = 1'h0;
		host.send(5'h14);
		cyc(2);
		chk(cfg === ARC_CFG_ALONE, 1'h1);
		chk(lvl, 1'h1);
		chk(hp & ~lp, 1'h1);
		chk(st.aux_alone_cfg & ~st.aux_share_cfg, 1'h1);
		host.send(5'h18);
		cyc(1);
		chk(fail, 1'h0);
		cyc(1);
		chk(cfg === ARC_CFG_ALONE, 1'h1);
		chk(lvl | ~en, 1'h0);
		uv = 1'h1;
		cyc(8);
		chk(en, 1'h0);
		chk(st.aux_undervoltage_flag, 1'h1);
		uv = 1'h0;
		cyc(8);
		chk(en, 1'h1);
		host.send(5'h12);
		uv = 1'h1;
		cyc(8);
		uv = 1'h0;
		cyc(8);
		chk(en, 1'h0);
		host.send(5'h10);
		sh = 1'h1;
		cyc(4);
		chk(st.aux_overcurrent_flag & lim & en, 1'h1);
		// Clear while the limit still holds: the set must win
		clr = 1'h1;
		cyc(1);
		chk(st.aux_overcurrent_flag, 1'h1);
		sh = 1'h0;
		cyc(1);
		clr = 1'h0;
		cyc(3);
		chk(st.aux_overcurrent_flag, 1'h0);
	endtask
	initial begin
		sys_clk_in = 1'h0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// Limit well above the roughly 100 cycles the scenarios need
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		rst = 1'h1;
		por = 1'h1;
		mode = ARC_MODE_NORMAL;
		m_lvl = 1'h0;
		m_en = 1'h1;
		uv = 1'h0;
		sh = 1'h0;
		clr = 1'h0;
		cyc(5);
		rst = 1'h0;
		por = 1'h0;
		t_share();
		t_alone();
		end_of_test();
	end
endmodule
